// ### srrs_mem_model.sv
`timescale 1ns/1ps
// stack memory: one read at a time, answered after a chosen wait
module srrs_mem_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] wait_in,
  input wire logic req_in,
  input wire logic [15:0] seg_in,
  input wire logic [15:0] ofs_in,
  output logic ack_out,
  output logic [15:0] rdata_out
);
  logic [1:0] cnt_q;
  // data is a scramble of the address; off the ack the bus toggles
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      rdata_out <= 16'hFFFF;
      cnt_q <= 2'h0;
    end else begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out; // stale data must never look valid
      if (req_in && !ack_out) begin
        if (cnt_q == wait_in) begin
          ack_out <= 1'b1;
          rdata_out <= ofs_in ^ seg_in ^ 16'hC35A;
          cnt_q <= 2'h0;
        end else begin
          cnt_q <= cnt_q + 2'h1;
        end
      end
    end
  end
endmodule : srrs_mem_model

// ### srrs_mem_port.sv
`timescale 1ns/1ps
// single outstanding read toward system memory; data held in a register
module srrs_mem_port (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire logic [15:0] seg_in,
  input wire logic [15:0] ofs_in,
  output logic busy_out,
  output logic done_out,
  output logic [15:0] rdata_out,
  output logic mem_req_out,
  output logic [15:0] mem_seg_out,
  output logic [15:0] mem_ofs_out,
  input wire logic mem_ack_in,
  input wire logic [15:0] mem_rdata_in
);
  // request stays up until memory acknowledges
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_req_out <= 1'b0;
      mem_seg_out <= 16'h0000;
      mem_ofs_out <= 16'h0000;
      rdata_out <= 16'h0000;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (mem_req_out && mem_ack_in) begin
        mem_req_out <= 1'b0;
        rdata_out <= mem_rdata_in;
        done_out <= 1'b1;
      end else if (req_in && !mem_req_out) begin
        mem_req_out <= 1'b1;
        mem_seg_out <= seg_in;
        mem_ofs_out <= ofs_in;
      end
    end
  end
  assign busy_out = mem_req_out;
endmodule : srrs_mem_port

// ### srrs_pad.sv
`timescale 1ns/1ps
// stalls completion until an instruction has used its documented clock budget
module srrs_pad #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [W-1:0] budget_in,
  output logic expired_out
);
  logic [W-1:0] cnt_q;
  // load the budget, then count down to zero; expired at one or below
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
    end else if (load_in) begin
      cnt_q <= budget_in;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end
  assign expired_out = (cnt_q <= W'(1)) && !load_in;
endmodule : srrs_pad

// ### srrs_pkg.sv
package srrs_pkg;
  // prefix and opcode encodings
  localparam logic [7:0] PFX_UNEQUAL = 8'hF2;
  localparam logic [7:0] PFX_EQUAL = 8'hF3;
  localparam logic [7:0] OP_CMP_B = 8'hA6;
  localparam logic [7:0] OP_CMP_W = 8'hA7;
  localparam logic [7:0] OP_SCAN_B = 8'hAE;
  localparam logic [7:0] OP_SCAN_W = 8'hAF;
  localparam logic [7:0] OP_RET_NEAR = 8'hC3;
  localparam logic [7:0] OP_RET_FAR = 8'hCB;
  localparam logic [7:0] OP_RET_NEAR_IMM = 8'hC2;
  localparam logic [7:0] OP_RET_FAR_IMM = 8'hCA;
  // clock figures, in core clocks
  localparam logic [7:0] CLK_REP_SETUP = 8'h05;
  localparam logic [7:0] CLK_REP_SETUP_W8 = 8'h09;
  localparam logic [7:0] CLK_CMP_ITER = 8'h16;
  localparam logic [7:0] CLK_SCAN_ITER = 8'h0F;
  localparam logic [7:0] CLK_RET_NEAR = 8'h10;
  localparam logic [7:0] CLK_RET_NEAR_W8 = 8'h14;
  localparam logic [7:0] CLK_RET_FAR = 8'h16;
  localparam logic [7:0] CLK_RET_FAR_W8 = 8'h1E;
  localparam logic [7:0] CLK_RET_NEAR_IMM = 8'h12;
  localparam logic [7:0] CLK_RET_NEAR_IMM_W8 = 8'h16;
  localparam logic [7:0] CLK_RET_FAR_IMM = 8'h19;
  localparam logic [7:0] CLK_RET_FAR_IMM_W8 = 8'h21;
  localparam logic [15:0] POP_STEP = 16'h0002;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_REP_SETUP = 8'h02,
    ST_REP_IRQ = 8'h04,
    ST_REP_EXEC = 8'h08,
    ST_POP_OFS = 8'h10,
    ST_POP_SEG = 8'h20,
    ST_RELEASE = 8'h40,
    ST_DONE = 8'h80
  } srrs_state_e;
endpackage : srrs_pkg

// ### srrs_props.sv
`timescale 1ns/1ps
// port-level timing and ordering checks for the sequencer
module srrs_props #(
  parameter bit NARROW_BUS = 1'b0
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic START_IN,
  input wire logic [7:0] PREFIX_IN,
  input wire logic [7:0] OPCODE_IN,
  input wire logic [15:0] INSN_ADDR_IN,
  input wire logic [15:0] COUNT_REGISTER_IN,
  input wire logic [15:0] STACK_POINTER_IN,
  input wire logic [15:0] STACK_SEGMENT_IN,
  input wire logic STR_GO_OUT,
  input wire logic STR_SCAN_OUT,
  input wire logic STR_WORD_OUT,
  input wire logic STR_DONE_IN,
  input wire logic ZERO_FLAG_IN,
  input wire logic IRQ_ACK_OUT,
  input wire logic [15:0] IRQ_RESUME_ADDR_OUT,
  input wire logic MEM_REQ_OUT,
  input wire logic [15:0] MEM_SEG_OUT,
  input wire logic [15:0] MEM_OFS_OUT,
  input wire logic MEM_ACK_IN,
  input wire logic [15:0] COUNT_REGISTER_OUT,
  input wire logic RET_LOAD_OUT,
  input wire logic DONE_OUT,
  input wire logic BUSY_OUT,
  input wire logic ILLEGAL_OUT
);
  logic acc;
  logic [7:0] op_q, pfx_q;
  logic [15:0] ia_q, base_q, cyc_q;
  logic [1:0] pops_q;
  // an instruction counts only when the sequencer is free
  assign acc = START_IN && !BUSY_OUT;
  // remember the accepted instruction, cycles and finished pops since
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      op_q <= 8'h00;
      pfx_q <= 8'h00;
      ia_q <= 16'h0000;
      base_q <= 16'h0000;
      cyc_q <= 16'h0000;
      pops_q <= 2'h0;
    end else if (acc) begin
      op_q <= OPCODE_IN;
      pfx_q <= PREFIX_IN;
      ia_q <= INSN_ADDR_IN;
      base_q <= STACK_POINTER_IN;
      cyc_q <= 16'h0001;
      pops_q <= 2'h0;
    end else begin
      if (cyc_q != 16'hFFFF) cyc_q <= cyc_q + 16'h0001; // saturate, never wrap
      if (MEM_REQ_OUT && MEM_ACK_IN) pops_q <= pops_q + 2'h1;
    end
  end
  // shortest legal return time for each return form
  function automatic logic [7:0] min_ret(input logic [7:0] op);
    case (op)
      srrs_pkg::OP_RET_NEAR: min_ret = NARROW_BUS ? srrs_pkg::CLK_RET_NEAR_W8 :
        srrs_pkg::CLK_RET_NEAR;
      srrs_pkg::OP_RET_FAR: min_ret = NARROW_BUS ? srrs_pkg::CLK_RET_FAR_W8 :
        srrs_pkg::CLK_RET_FAR;
      srrs_pkg::OP_RET_NEAR_IMM: min_ret = NARROW_BUS ? srrs_pkg::CLK_RET_NEAR_IMM_W8 :
        srrs_pkg::CLK_RET_NEAR_IMM;
      srrs_pkg::OP_RET_FAR_IMM: min_ret = NARROW_BUS ? srrs_pkg::CLK_RET_FAR_IMM_W8 :
        srrs_pkg::CLK_RET_FAR_IMM;
      default: min_ret = 8'h00;
    endcase
  endfunction : min_ret
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  property p_ret_time;
    DONE_OUT && RET_LOAD_OUT |-> cyc_q >= {8'h00, min_ret(op_q)};
  endproperty
  a_ret_time: assert property (p_ret_time)
    else $error("return finished early");
  property p_pop_addr;
    MEM_REQ_OUT |-> MEM_SEG_OUT == STACK_SEGMENT_IN &&
      MEM_OFS_OUT == base_q + {13'h0000, pops_q, 1'b0};
  endproperty
  a_pop_addr: assert property (p_pop_addr)
    else $error("stack read address wrong");
  property p_req_hold;
    MEM_REQ_OUT && !MEM_ACK_IN |=> MEM_REQ_OUT && $stable(MEM_OFS_OUT);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("stack read dropped");
  property p_pops;
    DONE_OUT && RET_LOAD_OUT |-> pops_q == (op_q[3] ? 2'h2 : 2'h1);
  endproperty
  a_pops: assert property (p_pops) else $error("wrong number of pops");
  property p_kind;
    STR_GO_OUT |-> STR_SCAN_OUT == op_q[3] && STR_WORD_OUT == op_q[0];
  endproperty
  a_kind: assert property (p_kind) else $error("string kind wrong");
  property p_dec;
    STR_GO_OUT && STR_DONE_IN |=> COUNT_REGISTER_OUT == $past(COUNT_REGISTER_OUT) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("count not decremented");
  property p_zero;
    acc && COUNT_REGISTER_IN == 16'h0000 && OPCODE_IN[7:4] == 4'hA &&
      (PREFIX_IN == srrs_pkg::PFX_UNEQUAL || PREFIX_IN == srrs_pkg::PFX_EQUAL)
      |=> !STR_GO_OUT throughout (##[0:40] DONE_OUT);
  endproperty
  a_zero: assert property (p_zero) else $error("iteration with empty count");
  property p_irq;
    IRQ_ACK_OUT |-> !STR_GO_OUT && IRQ_RESUME_ADDR_OUT == ia_q;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt point wrong");
  property p_stop;
    STR_GO_OUT && STR_DONE_IN && (COUNT_REGISTER_OUT == 16'h0001 ||
      ZERO_FLAG_IN == (pfx_q == srrs_pkg::PFX_UNEQUAL)) |-> ##[1:30] DONE_OUT;
  endproperty
  a_stop: assert property (p_stop) else $error("loop did not stop");
  c_far_imm: cover property (DONE_OUT && RET_LOAD_OUT && op_q == srrs_pkg::OP_RET_FAR_IMM);
  c_irq: cover property (IRQ_ACK_OUT);
  c_ill: cover property (ILLEGAL_OUT);
endmodule : srrs_props

bind srrs_seq srrs_props #(.NARROW_BUS(NARROW_BUS)) i_srrs_props (.CLK_IN(CLK_IN),
  .RST_N_IN(RST_N_IN), .START_IN(START_IN), .PREFIX_IN(PREFIX_IN), .OPCODE_IN(OPCODE_IN),
  .INSN_ADDR_IN(INSN_ADDR_IN), .COUNT_REGISTER_IN(COUNT_REGISTER_IN),
  .STACK_POINTER_IN(STACK_POINTER_IN), .STACK_SEGMENT_IN(STACK_SEGMENT_IN),
  .STR_GO_OUT(STR_GO_OUT), .STR_SCAN_OUT(STR_SCAN_OUT), .STR_WORD_OUT(STR_WORD_OUT),
  .STR_DONE_IN(STR_DONE_IN), .ZERO_FLAG_IN(ZERO_FLAG_IN), .IRQ_ACK_OUT(IRQ_ACK_OUT),
  .IRQ_RESUME_ADDR_OUT(IRQ_RESUME_ADDR_OUT), .MEM_REQ_OUT(MEM_REQ_OUT),
  .MEM_SEG_OUT(MEM_SEG_OUT), .MEM_OFS_OUT(MEM_OFS_OUT), .MEM_ACK_IN(MEM_ACK_IN),
  .COUNT_REGISTER_OUT(COUNT_REGISTER_OUT), .RET_LOAD_OUT(RET_LOAD_OUT), .DONE_OUT(DONE_OUT),
  .BUSY_OUT(BUSY_OUT), .ILLEGAL_OUT(ILLEGAL_OUT));

// ### srrs_seq.sv
`timescale 1ns/1ps
module srrs_seq #(
  parameter bit NARROW_BUS = 1'b0
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // decoded instruction from the fetch stage
  input wire logic START_IN,
  input wire logic [7:0] PREFIX_IN,
  input wire logic [7:0] OPCODE_IN,
  input wire logic [15:0] IMM_IN,
  input wire logic [15:0] INSN_ADDR_IN,
  input wire logic [15:0] COUNT_REGISTER_IN,
  input wire logic [15:0] STACK_POINTER_IN,
  input wire logic [15:0] STACK_SEGMENT_IN,
  input wire logic [15:0] CODE_SEGMENT_IN,
  // string primitive engine
  output logic STR_GO_OUT,
  output logic STR_SCAN_OUT,
  output logic STR_WORD_OUT,
  input wire logic STR_DONE_IN,
  input wire logic ZERO_FLAG_IN,
  // interrupt controller
  input wire logic IRQ_PENDING_IN,
  output logic IRQ_ACK_OUT,
  output logic [15:0] IRQ_RESUME_ADDR_OUT,
  input wire logic IRQ_SERVICED_IN,
  // memory for stack reads
  output logic MEM_REQ_OUT,
  output logic [15:0] MEM_SEG_OUT,
  output logic [15:0] MEM_OFS_OUT,
  input wire logic MEM_ACK_IN,
  input wire logic [15:0] MEM_RDATA_IN,
  // architectural results
  output logic [15:0] COUNT_REGISTER_OUT,
  output logic [15:0] STACK_POINTER_OUT,
  output logic [15:0] INSTRUCTION_POINTER_OUT,
  output logic [15:0] CODE_SEGMENT_OUT,
  output logic RET_LOAD_OUT,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic ILLEGAL_OUT
);
  srrs_pkg::srrs_state_e state_q;
  logic [15:0] count_q;
  logic [15:0] stk_ptr_q;
  logic [15:0] ret_ofs_q;
  logic [15:0] cs_q;
  logic [15:0] imm_q;
  logic [15:0] resume_q;
  logic stop_on_set_q;
  logic scan_q;
  logic word_q;
  logic far_q;
  logic has_imm_q;
  logic ret_load_q;
  logic ret_flag_q;
  logic str_done_q;
  logic zero_flag_q;
  logic done_q;
  logic illegal_q;
  logic is_rep_pfx;
  logic is_str_op;
  logic is_ret_op;
  logic rep_stop;
  logic pad_load;
  logic [15:0] pad_budget;
  logic pad_expired;
  logic pop_req;
  logic pop_busy;
  logic pop_done;
  logic [15:0] pop_data;

  // decode: both repeat spellings share one encoding each
  assign is_rep_pfx = (PREFIX_IN == srrs_pkg::PFX_UNEQUAL) ||
    (PREFIX_IN == srrs_pkg::PFX_EQUAL);
  assign is_str_op = (OPCODE_IN == srrs_pkg::OP_CMP_B) || (OPCODE_IN == srrs_pkg::OP_CMP_W) ||
    (OPCODE_IN == srrs_pkg::OP_SCAN_B) || (OPCODE_IN == srrs_pkg::OP_SCAN_W);
  assign is_ret_op = (OPCODE_IN == srrs_pkg::OP_RET_NEAR) ||
    (OPCODE_IN == srrs_pkg::OP_RET_FAR) || (OPCODE_IN == srrs_pkg::OP_RET_NEAR_IMM) ||
    (OPCODE_IN == srrs_pkg::OP_RET_FAR_IMM);

  // exit test after decrement; prefix picks which flag sense
  assign rep_stop = (count_q == 16'h0000) ||
    (stop_on_set_q ? zero_flag_q : !zero_flag_q);

  // per-iteration and per-instruction clock budget
  always_comb begin
    pad_load = 1'b0;
    pad_budget = 16'h0000;
    if (state_q == srrs_pkg::ST_IDLE && START_IN) begin
      pad_load = 1'b1;
      if (is_rep_pfx && is_str_op) begin
        // word form on the narrow bus pays four more setup clocks
        pad_budget = {8'h00, (NARROW_BUS && OPCODE_IN[0]) ?
          srrs_pkg::CLK_REP_SETUP_W8 : srrs_pkg::CLK_REP_SETUP};
      end else begin
        case (OPCODE_IN)
          srrs_pkg::OP_RET_NEAR: pad_budget = {8'h00, NARROW_BUS ?
            srrs_pkg::CLK_RET_NEAR_W8 : srrs_pkg::CLK_RET_NEAR};
          srrs_pkg::OP_RET_FAR: pad_budget = {8'h00, NARROW_BUS ?
            srrs_pkg::CLK_RET_FAR_W8 : srrs_pkg::CLK_RET_FAR};
          srrs_pkg::OP_RET_NEAR_IMM: pad_budget = {8'h00, NARROW_BUS ?
            srrs_pkg::CLK_RET_NEAR_IMM_W8 : srrs_pkg::CLK_RET_NEAR_IMM};
          srrs_pkg::OP_RET_FAR_IMM: pad_budget = {8'h00, NARROW_BUS ?
            srrs_pkg::CLK_RET_FAR_IMM_W8 : srrs_pkg::CLK_RET_FAR_IMM};
          default: pad_budget = 16'h0001;
        endcase
      end
    end else if (state_q == srrs_pkg::ST_REP_IRQ && !IRQ_PENDING_IN) begin
      // iteration budget starts when the primitive is launched
      pad_load = 1'b1;
      pad_budget = {8'h00, scan_q ? srrs_pkg::CLK_SCAN_ITER :
        srrs_pkg::CLK_CMP_ITER};
    end
  end

  srrs_pad #(
    .W(16)
  ) u_pad (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .load_in(pad_load),
    .budget_in(pad_budget),
    .expired_out(pad_expired)
  );

  // stack reads go through one outstanding request
  assign pop_req = (state_q == srrs_pkg::ST_POP_OFS || state_q == srrs_pkg::ST_POP_SEG) &&
    !pop_busy && !pop_done;

  srrs_mem_port u_mem (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .req_in(pop_req),
    .seg_in(STACK_SEGMENT_IN),
    .ofs_in(stk_ptr_q),
    .busy_out(pop_busy),
    .done_out(pop_done),
    .rdata_out(pop_data),
    .mem_req_out(MEM_REQ_OUT),
    .mem_seg_out(MEM_SEG_OUT),
    .mem_ofs_out(MEM_OFS_OUT),
    .mem_ack_in(MEM_ACK_IN),
    .mem_rdata_in(MEM_RDATA_IN)
  );

  // sequencer; flags are never written here, only sampled
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= srrs_pkg::ST_IDLE;
    end else begin
      case (state_q)
        srrs_pkg::ST_IDLE: begin
          if (START_IN && is_rep_pfx && is_str_op) begin
            state_q <= srrs_pkg::ST_REP_SETUP;
          end else if (START_IN && is_ret_op) begin
            state_q <= srrs_pkg::ST_POP_OFS;
          end else if (START_IN) begin
            state_q <= srrs_pkg::ST_DONE;
          end
        end
        srrs_pkg::ST_REP_SETUP: begin
          if (pad_expired) begin
            // zero count skips the loop entirely
            state_q <= (count_q == 16'h0000) ? srrs_pkg::ST_DONE : srrs_pkg::ST_REP_IRQ;
          end
        end
        srrs_pkg::ST_REP_IRQ: begin
          if (!IRQ_PENDING_IN) begin
            state_q <= srrs_pkg::ST_REP_EXEC;
          end
        end
        srrs_pkg::ST_REP_EXEC: begin
          if (str_done_q && pad_expired) begin
            state_q <= rep_stop ? srrs_pkg::ST_DONE : srrs_pkg::ST_REP_IRQ;
          end
        end
        srrs_pkg::ST_POP_OFS: begin
          if (pop_done) begin
            state_q <= far_q ? srrs_pkg::ST_POP_SEG :
              (has_imm_q ? srrs_pkg::ST_RELEASE : srrs_pkg::ST_DONE);
          end
        end
        srrs_pkg::ST_POP_SEG: begin
          if (pop_done) begin
            state_q <= has_imm_q ? srrs_pkg::ST_RELEASE : srrs_pkg::ST_DONE;
          end
        end
        srrs_pkg::ST_RELEASE: state_q <= srrs_pkg::ST_DONE;
        srrs_pkg::ST_DONE: begin
          if (pad_expired) begin
            state_q <= srrs_pkg::ST_IDLE;
          end
        end
        default: state_q <= srrs_pkg::ST_IDLE;
      endcase
    end
  end

  // latch the decoded instruction
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      stop_on_set_q <= 1'b0;
      scan_q <= 1'b0;
      word_q <= 1'b0;
      far_q <= 1'b0;
      has_imm_q <= 1'b0;
      imm_q <= srrs_pkg::RESET_WORD;
      resume_q <= srrs_pkg::RESET_WORD;
      illegal_q <= 1'b0;
    end else if (state_q == srrs_pkg::ST_IDLE && START_IN) begin
      stop_on_set_q <= (PREFIX_IN == srrs_pkg::PFX_UNEQUAL);
      scan_q <= OPCODE_IN[3];
      word_q <= OPCODE_IN[0];
      far_q <= OPCODE_IN[3];
      has_imm_q <= !OPCODE_IN[0];
      imm_q <= IMM_IN;
      resume_q <= INSN_ADDR_IN;
      // anything else is not ours to run
      illegal_q <= !((is_rep_pfx && is_str_op) || is_ret_op);
    end
  end

  // primitive result held; the done pulse may come long before the budget ends
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      str_done_q <= 1'b0;
      zero_flag_q <= 1'b0;
    end else if (state_q != srrs_pkg::ST_REP_EXEC) begin
      str_done_q <= 1'b0;
    end else if (STR_DONE_IN && !str_done_q) begin
      str_done_q <= 1'b1;
      zero_flag_q <= ZERO_FLAG_IN;
    end
  end

  // count register: loaded at start, decremented after each primitive
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      count_q <= srrs_pkg::RESET_WORD;
    end else if (state_q == srrs_pkg::ST_IDLE && START_IN) begin
      count_q <= COUNT_REGISTER_IN;
    end else if (state_q == srrs_pkg::ST_REP_EXEC && STR_DONE_IN && !str_done_q) begin
      count_q <= count_q - 16'h0001;
    end
  end

  // stack pointer: plus two per pop, immediate only after all pops
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      stk_ptr_q <= srrs_pkg::RESET_WORD;
    end else if (state_q == srrs_pkg::ST_IDLE && START_IN) begin
      stk_ptr_q <= STACK_POINTER_IN;
    end else if (pop_done) begin
      stk_ptr_q <= stk_ptr_q + srrs_pkg::POP_STEP;
    end else if (state_q == srrs_pkg::ST_RELEASE) begin
      stk_ptr_q <= stk_ptr_q + imm_q;
    end
  end

  // return target: offset first, then segment for far
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ret_ofs_q <= srrs_pkg::RESET_WORD;
      cs_q <= srrs_pkg::RESET_WORD;
      ret_load_q <= 1'b0;
    end else begin
      ret_load_q <= (state_q == srrs_pkg::ST_DONE) && pad_expired && ret_flag_q;
      if (state_q == srrs_pkg::ST_IDLE && START_IN) begin
        cs_q <= CODE_SEGMENT_IN;
      end else if (state_q == srrs_pkg::ST_POP_OFS && pop_done) begin
        ret_ofs_q <= pop_data;
      end else if (state_q == srrs_pkg::ST_POP_SEG && pop_done) begin
        cs_q <= pop_data;
      end
    end
  end

  // completion pulse marks the instruction retired
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == srrs_pkg::ST_DONE) && pad_expired;
    end
  end

  // interrupts are only taken before each iteration, never mid primitive
  assign IRQ_ACK_OUT = (state_q == srrs_pkg::ST_REP_IRQ) && IRQ_PENDING_IN;
  // resume point re-enters the prefixed instruction with live count
  assign IRQ_RESUME_ADDR_OUT = resume_q;
  // go drops as soon as the primitive reports, budget may still run
  assign STR_GO_OUT = (state_q == srrs_pkg::ST_REP_EXEC) && !str_done_q;
  assign STR_SCAN_OUT = scan_q;
  assign STR_WORD_OUT = word_q;
  assign COUNT_REGISTER_OUT = count_q;
  assign STACK_POINTER_OUT = stk_ptr_q;
  assign INSTRUCTION_POINTER_OUT = ret_ofs_q;
  assign CODE_SEGMENT_OUT = cs_q;
  assign RET_LOAD_OUT = ret_load_q;
  assign BUSY_OUT = (state_q != srrs_pkg::ST_IDLE);
  assign DONE_OUT = done_q;
  assign ILLEGAL_OUT = done_q && illegal_q;

  // remember whether the running instruction was a return
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ret_flag_q <= 1'b0;
    end else if (state_q == srrs_pkg::ST_IDLE && START_IN) begin
      ret_flag_q <= is_ret_op;
    end
  end
  // IRQ_SERVICED_IN is unused; the loop leaves the interrupt check state once IRQ_PENDING_IN drops
  logic unused_serviced;
  assign unused_serviced = IRQ_SERVICED_IN;
endmodule : srrs_seq

// ### tb_top.sv
`timescale 1ns/1ps
// drives decoded instructions, plays the string engine, scores on done
module tb_top;
  typedef struct {
    logic [15:0] cnt, ofs, cs, stk;
    logic ret, ill;
    int lo, hi;
  } srrs_exp_s;
  localparam bit NB = 1'b0;
  logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, sdone = 1'b0, zflg = 1'b0, irq = 1'b0;
  logic go_d = 1'b0, seen = 1'b0;
  logic [7:0] pfx = 8'h00, op = 8'h00;
  logic [15:0] imm = 16'h0000, ia = 16'h0000, cnt = 16'h0000;
  logic [15:0] stk_in = 16'h0000, ss = 16'h0000, cs = 16'h0000;
  logic [1:0] mw = 2'h0;
  logic go, scan, word, ack, mreq, mack, ipl, busy, done, ill;
  logic [15:0] rip, mseg, mofs, mrd, cnt_o, stk_o, ofs_o, cs_o;
  logic [7:0] rops [4] = '{srrs_pkg::OP_CMP_B, srrs_pkg::OP_CMP_W,
    srrs_pkg::OP_SCAN_B, srrs_pkg::OP_SCAN_W};
  logic [7:0] tops [4] = '{srrs_pkg::OP_RET_NEAR, srrs_pkg::OP_RET_FAR,
    srrs_pkg::OP_RET_NEAR_IMM, srrs_pkg::OP_RET_FAR_IMM};
  srrs_exp_s q[$];
  srrs_exp_s e;
  int mismatches = 0, num_checks = 0, cyc = 0, m = 0, iter = 0, wc = 0;
  srrs_seq #(.NARROW_BUS(NB)) i_srrs_seq (.CLK_IN(clk), .RST_N_IN(rst_n), .START_IN(start),
    .PREFIX_IN(pfx), .OPCODE_IN(op), .IMM_IN(imm), .INSN_ADDR_IN(ia),
    .COUNT_REGISTER_IN(cnt), .STACK_POINTER_IN(stk_in), .STACK_SEGMENT_IN(ss),
    .CODE_SEGMENT_IN(cs), .STR_GO_OUT(go), .STR_SCAN_OUT(scan), .STR_WORD_OUT(word),
    .STR_DONE_IN(sdone), .ZERO_FLAG_IN(zflg), .IRQ_PENDING_IN(irq), .IRQ_ACK_OUT(ack),
    .IRQ_RESUME_ADDR_OUT(rip), .IRQ_SERVICED_IN(ack), .MEM_REQ_OUT(mreq),
    .MEM_SEG_OUT(mseg), .MEM_OFS_OUT(mofs), .MEM_ACK_IN(mack), .MEM_RDATA_IN(mrd),
    .COUNT_REGISTER_OUT(cnt_o), .STACK_POINTER_OUT(stk_o), .INSTRUCTION_POINTER_OUT(ofs_o),
    .CODE_SEGMENT_OUT(cs_o), .RET_LOAD_OUT(ipl), .BUSY_OUT(busy), .DONE_OUT(done),
    .ILLEGAL_OUT(ill));
  srrs_mem_model i_srrs_mem_model (.clk_in(clk), .rst_n_in(rst_n), .wait_in(mw),
    .req_in(mreq), .seg_in(mseg), .ofs_in(mofs), .ack_out(mack), .rdata_out(mrd));
  // 250 MHz core clock
  initial forever #2 clk = ~clk;
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp16
  task automatic cmp_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("[ERR] t=%0t cycles=%h lo=%h hi=%h", $time, got, lo, hi);
    end
  endtask : cmp_rng
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // string engine: answers each run after 1..3 cycles, flag from match index
  always @(posedge clk) begin
    go_d <= go;
    sdone <= 1'b0;
    if (go && !go_d) wc <= 1 + $urandom % 3;
    else if (wc != 0) begin
      wc <= wc - 1;
      if (wc == 1) begin
        iter <= iter + 1;
        sdone <= 1'b1;
        zflg <= (pfx == srrs_pkg::PFX_UNEQUAL) ? (iter + 1 == m) : (iter + 1 != m);
      end
    end
  end
  // scoreboard: oldest note is compared whenever done shows
  always @(posedge clk) begin
    cyc <= (start && !busy) ? 1 : cyc + 1;
    if (done === 1'b1) begin
      seen <= 1'b1;
      if (q.size() == 0) cmp16(16'h0001, 16'h0000);
      else begin
        e = q.pop_front();
        if (e.ret) begin
          cmp16(ofs_o, e.ofs);
          cmp16(cs_o, e.cs);
          cmp16(stk_o, e.stk);
        end else if (!e.ill) cmp16(cnt_o, e.cnt);
        cmp16({15'h0000, ill}, {15'h0000, e.ill});
        cmp16({15'h0000, ipl}, {15'h0000, e.ret});
        cmp_rng(cyc, e.lo, e.hi);
      end
    end
  end
  // one instruction: note the expectation, start it, wait for done
  task automatic issue(input logic [7:0] p, input logic [7:0] o, input logic [15:0] n,
                       input int k, input int ix);
    srrs_exp_s x;
    logic [15:0] s, g, im;
    int it;
    s = 16'($urandom);
    g = 16'($urandom);
    im = 16'($urandom);
    x.ret = o[7:4] == 4'hC;
    x.ill = !x.ret && o[7:4] != 4'hA;
    it = (n < k) ? n : k;
    x.cnt = n - it[15:0];
    x.ofs = s ^ g ^ 16'hC35A;
    x.cs = o[3] ? ((s + 16'h0002) ^ g ^ 16'hC35A) : cs;
    x.stk = s + (o[3] ? 16'h0004 : 16'h0002) + (o[0] ? 16'h0000 : im); // imm ignored on C3/CB
    x.lo = (o[0] && NB) ? srrs_pkg::CLK_REP_SETUP_W8 : srrs_pkg::CLK_REP_SETUP;
    x.lo = x.lo + it * (o[3] ? srrs_pkg::CLK_SCAN_ITER : srrs_pkg::CLK_CMP_ITER);
    x.hi = x.lo + 6 * (it + 1) + ix;
    if (x.ret) begin
      x.lo = (o == tops[0]) ? 16 : (o == tops[1]) ? 22 : (o == tops[2]) ? 18 : 25;
      x.hi = x.lo + 8;
    end
    if (x.ill) begin
      x.lo = 1;
      x.hi = 30;
    end
    @(posedge clk);
    pfx <= p;
    op <= o;
    cnt <= n;
    imm <= im;
    stk_in <= s;
    ss <= g;
    ia <= 16'($urandom);
    mw <= 2'($urandom % 4);
    iter <= 0;
    m <= k;
    seen <= 1'b0;
    start <= 1'b1;
    q.push_back(x);
    @(posedge clk);
    start <= 1'b0;
    for (it = 0; it < 2000 && !seen; it++) begin
      irq <= (it < ix); // pending across setup and into the loop
      @(posedge clk);
    end
    if (!seen) begin
      mismatches++;
      wrap_up();
    end
  endtask : issue
  initial begin
    void'($urandom(32'hA9175B3B));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cs <= 16'($urandom);
    // every repeat form both prefixes; first two with empty count
    for (int i = 0; i < 16; i++) begin
      issue(i[3] ? srrs_pkg::PFX_EQUAL : srrs_pkg::PFX_UNEQUAL, rops[i % 4],
            (i < 2) ? 16'h0000 : 16'(1 + $urandom % 5), 1 + $urandom % 6, (i == 5) ? 12 : 0);
    end
    // every return form, twice with fresh stack state
    for (int i = 0; i < 8; i++) issue(8'h00, tops[i % 4], 16'h0000, 1, 0);
    issue(8'h00, 8'h90, 16'h0000, 1, 0); // unsupported opcode is flagged
    wrap_up();
  end
endmodule : tb_top
